// ===== common/ldr_pkg.sv
// constants for the led channel dimming register bank
package ldr_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DUTY_W   = 12;
  localparam int LOW_W    = 4;
  localparam int HIGH_W   = 8;
  localparam int CODE_W   = 6;
  localparam int NUM_SLOT = 4;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_CH3_DUTY_LOW     = 6'h11;
  localparam logic [5:0] IDX_CH3_DUTY_HIGH    = 6'h12;
  localparam logic [5:0] IDX_CH4_CURRENT_CODE = 6'h13;
  localparam logic [5:0] IDX_CH4_DUTY_LOW     = 6'h14;
  localparam logic [5:0] IDX_CH4_DUTY_HIGH    = 6'h15;
  localparam logic [5:0] IDX_CH5_CURRENT_CODE = 6'h16;
  localparam logic [5:0] IDX_CH5_DUTY_LOW     = 6'h17;
  localparam logic [5:0] IDX_CH5_DUTY_HIGH    = 6'h18;
  localparam logic [5:0] IDX_CH6_CURRENT_CODE = 6'h19;
  localparam logic [5:0] IDX_CH6_DUTY_LOW     = 6'h1A;
  localparam logic [5:0] IDX_CH6_DUTY_HIGH    = 6'h1B;
  localparam logic [5:0] IDX_CH7_CURRENT_CODE = 6'h1C;
  localparam logic [5:0] IDX_BANK_BASE        = 6'h10;
  localparam logic [5:0] REGS_PER_CH          = 6'h03;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [LOW_W-1:0]  RST_LOW  = 4'hF;
  localparam logic [HIGH_W-1:0] RST_HIGH = 8'hFF;
  localparam logic [CODE_W-1:0] RST_CODE = 6'h3F;

  // field held at one index
  typedef enum logic [1:0] {
    FLD_CODE = 2'b00,
    FLD_LOW  = 2'b01,
    FLD_HIGH = 2'b10,
    FLD_NONE = 2'b11
  } ldr_field_t;

endpackage

// ===== rtl/ldr_dimming_regs.sv
// apb register bank for led channel dimming, channels 3 to 7
// Function
// - low duty nibble per channel, reset ones
// - high duty byte per channel, reset ones
// - low write staged, high write applies duty
// - six bit current code, full scale 63
// - three registers per channel for channels 4 to 6, fixed order
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

module ldr_dimming_regs
  import ldr_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // applied pwm duty values
  output logic      [DUTY_W-1:0] ch3_duty_value,
  output logic      [DUTY_W-1:0] ch4_duty_value,
  output logic      [DUTY_W-1:0] ch5_duty_value,
  output logic      [DUTY_W-1:0] ch6_duty_value,
  // analog current codes
  output logic      [CODE_W-1:0] ch4_current_code,
  output logic      [CODE_W-1:0] ch5_current_code,
  output logic      [CODE_W-1:0] ch6_current_code,
  output logic      [CODE_W-1:0] ch7_current_code,
  // pwm dimming outputs
  output logic                   ch3_dim_pwm,
  output logic                   ch4_dim_pwm,
  output logic                   ch5_dim_pwm,
  output logic                   ch6_dim_pwm
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // decode reads the word index from paddr bits 7:2
  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // returns {field, slot}; code slot is channel-4, duty slot channel-3
  function automatic logic [3:0] reg_decode(input logic [5:0] idx);
    logic [5:0] off;
    logic [5:0] grp;
    logic [5:0] pos;
    ldr_field_t fld;
    logic [1:0] slot;
    off  = idx - IDX_BANK_BASE;
    grp  = off / REGS_PER_CH;
    pos  = off % REGS_PER_CH;
    fld  = FLD_NONE;
    slot = 2'h0;
    if (idx >= IDX_CH3_DUTY_LOW && idx <= IDX_CH7_CURRENT_CODE)
    begin
      if (pos == 6'h00)
      begin
        fld  = FLD_CODE;
        slot = 2'(grp - 6'h01);
      end
      else
      begin
        fld  = (pos == 6'h01) ? FLD_LOW : FLD_HIGH;
        slot = grp[1:0];
      end
    end
    return {fld, slot};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [LOW_W-1:0]  duty_low_reg  [NUM_SLOT];
  logic [LOW_W-1:0]  duty_low_next [NUM_SLOT];
  logic [HIGH_W-1:0] duty_high_reg [NUM_SLOT];
  logic [HIGH_W-1:0] duty_high_next[NUM_SLOT];
  logic [DUTY_W-1:0] duty_reg      [NUM_SLOT];
  logic [DUTY_W-1:0] duty_next     [NUM_SLOT];
  logic [CODE_W-1:0] code_reg      [NUM_SLOT];
  logic [CODE_W-1:0] code_next     [NUM_SLOT];
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pready_reg;
  logic              pready_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic [DUTY_W-1:0] pwm_cnt_reg;
  logic [DUTY_W-1:0] pwm_cnt_next;
  logic [NUM_SLOT-1:0] pwm_reg;
  logic [NUM_SLOT-1:0] pwm_next;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic       setup;
  logic       wr_en;
  logic       aligned;
  logic [3:0] dec;
  ldr_field_t dec_fld;
  logic [1:0] dec_slot;

  // address is stable over setup and access
  assign setup    = psel & ~penable;
  assign aligned  = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
  assign dec      = reg_decode(paddr[7:2]);
  assign dec_fld  = aligned ? ldr_field_t'(dec[3:2]) : FLD_NONE;
  assign dec_slot = dec[1:0];
  // write lands only at the edge that sees pready
  assign wr_en    = psel & penable & pready_reg & pwrite & pstrb[0]
                    & ~pslverr_reg;

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  // one cycle access: pready rises in the access phase
  always_comb
  begin
    pready_next  = setup;
    pslverr_next = setup & (dec_fld == FLD_NONE);
    prdata_next  = prdata_reg;
    if (setup)
    begin
      unique case (dec_fld)
        FLD_CODE: prdata_next = {26'h0, code_reg[dec_slot]};
        FLD_LOW:  prdata_next = {28'h0, duty_low_reg[dec_slot]};
        FLD_HIGH: prdata_next = {24'h0, duty_high_reg[dec_slot]};
        FLD_NONE: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------
  // dimming registers
  // ----------------------------------------
  // write path; upper bits of pwdata simply dropped
  always_comb
  begin
    duty_low_next  = duty_low_reg;
    duty_high_next = duty_high_reg;
    duty_next      = duty_reg;
    code_next      = code_reg;
    if (wr_en)
    begin
      unique case (dec_fld)
        FLD_CODE: code_next[dec_slot] = pwdata[CODE_W-1:0];
        FLD_LOW:  duty_low_next[dec_slot] = pwdata[LOW_W-1:0];
        FLD_HIGH:
        begin
          duty_high_next[dec_slot] = pwdata[HIGH_W-1:0];
          duty_next[dec_slot] = {pwdata[HIGH_W-1:0],
                                 duty_low_reg[dec_slot]};
        end
        FLD_NONE: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_SLOT; i++)
      begin
        duty_low_reg[i]  <= RST_LOW;
        duty_high_reg[i] <= RST_HIGH;
        duty_reg[i]      <= {RST_HIGH, RST_LOW};
        code_reg[i]      <= RST_CODE;
      end
    end
    else
    begin
      duty_low_reg  <= duty_low_next;
      duty_high_reg <= duty_high_next;
      duty_reg      <= duty_next;
      code_reg      <= code_next;
    end
  end

  // ----------------------------------------
  // pwm generation
  // ----------------------------------------
  // full code gives 4095 of 4096, never solid on
  always_comb
  begin
    pwm_cnt_next = pwm_cnt_reg + 12'h001;
    for (int i = 0; i < NUM_SLOT; i++)
    begin
      pwm_next[i] = (pwm_cnt_reg < duty_reg[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_cnt_reg <= 12'h000;
      pwm_reg     <= 4'h0;
    end
    else
    begin
      pwm_cnt_reg <= pwm_cnt_next;
      pwm_reg     <= pwm_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign ch3_duty_value   = duty_reg[0];
  assign ch4_duty_value   = duty_reg[1];
  assign ch5_duty_value   = duty_reg[2];
  assign ch6_duty_value   = duty_reg[3];
  assign ch4_current_code = code_reg[0];
  assign ch5_current_code = code_reg[1];
  assign ch6_current_code = code_reg[2];
  assign ch7_current_code = code_reg[3];
  assign ch3_dim_pwm      = pwm_reg[0];
  assign ch4_dim_pwm      = pwm_reg[1];
  assign ch5_dim_pwm      = pwm_reg[2];
  assign ch6_dim_pwm      = pwm_reg[3];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  for (genvar k = 0; k < NUM_SLOT; k++)
  begin : g_chk
    property p_low_staged;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && dec_fld == FLD_LOW && dec_slot == k)
      |=> $stable(duty_reg[k])
          && duty_low_reg[k] == $past(pwdata[3:0]);
    endproperty
    a_low_staged: assert property (p_low_staged)
      else $error("low duty write not staged");

    property p_high_apply;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && dec_fld == FLD_HIGH && dec_slot == k)
      |=> duty_reg[k] == {$past(pwdata[7:0]),
                          $past(duty_low_reg[k])};
    endproperty
    a_high_apply: assert property (p_high_apply)
      else $error("high duty write did not apply duty");

    property p_duty_hold;
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && dec_fld == FLD_HIGH && dec_slot == k)
      |=> $stable(duty_reg[k]);
    endproperty
    a_duty_hold: assert property (p_duty_hold)
      else $error("duty changed without high write");
  end

  property p_code_map;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && aligned && paddr[7:2] == IDX_CH5_CURRENT_CODE)
    |=> ch5_current_code == $past(pwdata[5:0])
        && $stable(ch4_current_code);
  endproperty
  a_code_map: assert property (p_code_map)
    else $error("current code write misplaced");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && aligned && paddr[7:2] == IDX_CH6_DUTY_HIGH)
    |=> ch6_duty_value[11:4] == $past(pwdata[7:0])
        && $stable(ch5_duty_value);
  endproperty
  a_order: assert property (p_order)
    else $error("channel register order wrong");

  property p_code_rsvd;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && dec_fld == FLD_CODE)
    |=> pready && prdata[31:6] == 26'h0 && !pslverr;
  endproperty
  a_code_rsvd: assert property (p_code_rsvd)
    else $error("reserved code bits read nonzero");

  property p_low_rsvd;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && dec_fld == FLD_LOW)
    |=> prdata[31:4] == 28'h0
        && prdata[3:0] == $past(duty_low_reg[dec_slot]);
  endproperty
  a_low_rsvd: assert property (p_low_rsvd)
    else $error("low duty read wrong");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready not a single access cycle");

endmodule

// ===== testbench/ldr_dimming_regs_test.sv
// self-checking apb bench for the led dimming register bank
`timescale 1ns/1ps

module ldr_dimming_regs_test;
  import ldr_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [DUTY_W-1:0] duty [3:6];
  logic [CODE_W-1:0] code [4:7];
  logic              dim  [3:6];
  logic [31:0]       rd;
  logic              er;
  int                err_total;
  int                check_count;
  int                cyc;

  ldr_dimming_regs ldr_dimming_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch3_duty_value(duty[3]), .ch4_duty_value(duty[4]),
    .ch5_duty_value(duty[5]), .ch6_duty_value(duty[6]),
    .ch4_current_code(code[4]), .ch5_current_code(code[5]),
    .ch6_current_code(code[6]), .ch7_current_code(code[7]),
    .ch3_dim_pwm(dim[3]), .ch4_dim_pwm(dim[4]),
    .ch5_dim_pwm(dim[5]), .ch6_dim_pwm(dim[6]));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t flag %b want %b", $time, got, exp);
    end
  endtask

  // one apb transfer; held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no timeout here; if pready never rises, only the bench hang guard ends this wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
    chk1(er, 1'b0);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
    chk1(er, 1'b0);
  endtask

  // hang guard, far above the few hundred cycles used
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] a;
    logic [3:0] nb;
    logic [7:0] hb;
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk1(dim[3], 1'b1); // reset duty drives high
    for (int c = 4; c <= 6; c++)
      chk1(dim[c], 1'b1);
    // reset values by position: low, high, code repeating
    for (int i = 8'h11; i <= 8'h1C; i++)
    begin
      a = 8'(i * 4);
      case ((i - 8'h11) % 3)
        0: rchk(a, 32'h0000_000F);
        1: rchk(a, 32'h0000_00FF);
        default: rchk(a, 32'h0000_003F);
      endcase
    end
    for (int c = 4; c <= 7; c++)
      chk(32'(code[c]), 32'h3F);
    // duty staging per channel, upper junk ignored
    for (int c = 3; c <= 6; c++)
    begin
      a  = 8'(8'h44 + 12 * (c - 3));
      nb = 4'(c + 6);
      hb = 8'(8'h21 * c);
      wr(a, {28'hFFFFFFF, nb});
      rchk(a, {28'h0, nb});
      chk(32'(duty[c]), 32'hFFF);
      wr(a + 8'h04, {24'hABCDEF, hb});
      rchk(a + 8'h04, {24'h0, hb});
      chk(32'(duty[c]), {20'h0, hb, nb});
      wr(a, 32'h0000_0003);
      chk(32'(duty[c]), {20'h0, hb, nb});
      rchk(a, 32'h0000_0003);
    end
    // current codes, reserved bits dropped
    for (int c = 4; c <= 7; c++)
    begin
      a = 8'(8'h4C + 12 * (c - 4));
      wr(a, 32'hFFFF_FFC0 | 32'(c * 5));
      rchk(a, 32'(c * 5));
      chk(32'(code[c]), 32'(c * 5));
    end
    // write with byte lane 0 off has no effect
    xfer(1'b1, 8'h4C, 32'h0000_0001, 4'hE);
    rchk(8'h4C, 32'h0000_0014);
    // unmapped, unaligned and outside-bank places refused
    xfer(1'b0, 8'h40, 32'h0, 4'h0);
    chk1(er, 1'b1);
    chk(rd, 32'h0);
    xfer(1'b1, 8'h4D, 32'h0000_0001, 4'hF);
    chk1(er, 1'b1);
    xfer(1'b1, 8'h74, 32'h0000_0001, 4'hF);
    chk1(er, 1'b1);
    rchk(8'h4C, 32'h0000_0014);
    // mid-run reset brings written registers back to ones
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(duty[4]), 32'hFFF);
    rchk(8'h50, 32'h0000_000F);
    rchk(8'h54, 32'h0000_00FF);
    rchk(8'h4C, 32'h0000_003F);
    // zero duty keeps the pwm output low
    wr(8'h44, 32'h0);
    wr(8'h48, 32'h0);
    repeat (20)
    begin
      @(negedge pclk);
      chk1(dim[3], 1'b0);
    end
    test_done();
  end

endmodule
